// ==== logic/mrsirq_defs.vh ====
// register offsets, field positions and reset values of the sensor interrupt block
`ifndef MRSIRQ_DEFS_VH
`define MRSIRQ_DEFS_VH

`define MRSIRQ_ADDR_W        4
`define MRSIRQ_OFF_FLAGS     4'h0
`define MRSIRQ_OFF_ENABLES   4'h4
`define MRSIRQ_OFF_STATUS    4'h8

`define MRSIRQ_BIT_UNIT      12
`define MRSIRQ_BIT_EVT2      10
`define MRSIRQ_BIT_EVT1      9
`define MRSIRQ_BIT_EVT0      8
`define MRSIRQ_BIT_CMP1      7
`define MRSIRQ_BIT_CMP0      5
`define MRSIRQ_BIT_DROP      3
`define MRSIRQ_BIT_STOP      2
`define MRSIRQ_BIT_REV       1
`define MRSIRQ_BIT_FWD       0

`define MRSIRQ_FLAG_MASK     16'h17af
`define MRSIRQ_EN_MASK       16'h1fff
`define MRSIRQ_FLAGS_RST     16'h0000
`define MRSIRQ_ENABLES_RST   16'h0000

`define MRSIRQ_STAT_PHASE_LO 0
`define MRSIRQ_STAT_ACTIVE   4

`endif

// ==== logic/mrsirq_unit_match.v ====
// unit counter compare match detector, one pulse per arrival at the compare value
`timescale 1ns/10ps
module mrsirq_unit_match
(
  input  wire        clk_in,
  input  wire        srst_in,
  input  wire [11:0] unit_count_in,
  input  wire [11:0] unit_compare_in,
  output wire        match_pulse_out
);

  reg  match_reg;
  wire match_now;

  assign match_now = (unit_count_in == unit_compare_in);

  always @(posedge clk_in)
  begin
    if (srst_in)
      match_reg <= 1'b0;
    else
      match_reg <= match_now;
  end

  // a counter parked on the compare value raises the cause only once
  assign match_pulse_out = match_now & ~match_reg;

endmodule

// ==== logic/mrsirq_top.v ====
// interrupt flags, enables and status readout of the magnetoresistive sensor controller
//
// The implementer's own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
`include "mrsirq_defs.vh"

module mrsirq_top
(
  input  wire        clk_in,
  input  wire        srst_in,
  // avalon-mm slave
  input  wire [3:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output reg  [31:0] avs_readdata_out,
  output wire        avs_waitrequest_out,
  output reg  [1:0]  avs_response_out,
  // cause inputs from the measurement logic: unit count and compare values, then one-cycle pulses
  input  wire [11:0] unit_count_in,
  input  wire [11:0] unit_compare_in,
  input  wire        evt2_underflow_in,
  input  wire        evt1_underflow_in,
  input  wire        evt0_underflow_in,
  input  wire        cmp1_change_in,
  input  wire        cmp0_change_in,
  input  wire        phase_drop_in,
  input  wire        stop_detect_in,
  input  wire        reverse_detect_in,
  input  wire        forward_detect_in,
  // measurement state, then the interrupt request output
  input  wire        measuring_active_in,
  input  wire [2:0]  phase_number_in,
  output wire        irq_out
);

  reg  [15:0] interrupt_flags_reg;
  reg  [15:0] interrupt_flags_next;
  reg  [15:0] interrupt_enables_reg;
  reg  [15:0] interrupt_enables_next;
  reg  [15:0] sensor_status_reg;
  reg         ack_reg;
  wire        unit_match_pulse;
  wire [15:0] cause_vec;
  wire        access;
  wire        wr_fire;
  wire        ans_load;
  wire [15:0] wr_mask;

  // 16-bit registers live in the low two byte lanes
  function [15:0] lane_mask;
    input [3:0] be;
    begin
      lane_mask = {{8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  function mapped;
    input [3:0] addr;
    begin
      mapped = (addr == `MRSIRQ_OFF_FLAGS) || (addr == `MRSIRQ_OFF_ENABLES) ||
               (addr == `MRSIRQ_OFF_STATUS);
    end
  endfunction

  mrsirq_unit_match u_unit_match
  (
    .clk_in          (clk_in),
    .srst_in         (srst_in),
    .unit_count_in   (unit_count_in),
    .unit_compare_in (unit_compare_in),
    .match_pulse_out (unit_match_pulse)
  );

  assign cause_vec = {3'b000,
                      unit_match_pulse,
                      1'b0,
                      evt2_underflow_in,
                      evt1_underflow_in,
                      evt0_underflow_in,
                      cmp1_change_in,
                      1'b0,
                      cmp0_change_in,
                      1'b0,
                      phase_drop_in,
                      stop_detect_in,
                      reverse_detect_in,
                      forward_detect_in};

  // one wait cycle per access: the answer comes the cycle after the request
  assign access              = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = access & ~ack_reg;
  assign wr_fire             = avs_write_in & ack_reg;
  // answer is loaded in the wait cycle so it already stands when waitrequest falls
  assign ans_load            = access & ~ack_reg;
  assign wr_mask             = lane_mask(avs_byteenable_in);

  always @(posedge clk_in)
  begin
    if (srst_in)
      ack_reg <= 1'b0;
    else
      ack_reg <= access & ~ack_reg;
  end

  always @*
  begin
    interrupt_flags_next = interrupt_flags_reg;
    if (wr_fire && (avs_address_in == `MRSIRQ_OFF_FLAGS))
      interrupt_flags_next = interrupt_flags_next & ~(avs_writedata_in[15:0] & wr_mask);
    // a cause in the clearing cycle wins, regardless of its enable
    interrupt_flags_next = (interrupt_flags_next | cause_vec) & `MRSIRQ_FLAG_MASK;
  end

  always @*
  begin
    interrupt_enables_next = interrupt_enables_reg;
    if (wr_fire && (avs_address_in == `MRSIRQ_OFF_ENABLES))
      interrupt_enables_next = ((avs_writedata_in[15:0] & wr_mask) | (interrupt_enables_reg & ~wr_mask))
                               & `MRSIRQ_EN_MASK;
  end

  always @(posedge clk_in)
  begin
    if (srst_in)
    begin
      interrupt_flags_reg   <= `MRSIRQ_FLAGS_RST;
      interrupt_enables_reg <= `MRSIRQ_ENABLES_RST;
      sensor_status_reg     <= 16'h0000;
    end
    else
    begin
      interrupt_flags_reg   <= interrupt_flags_next;
      interrupt_enables_reg <= interrupt_enables_next;
      // phase is sampled live, so software must confirm it by a repeat read
      sensor_status_reg     <= {11'h000, measuring_active_in, 1'b0, phase_number_in};
    end
  end

  // reserved enable bits 4, 6 and 11 are stored but never gate anything; bits 15:13 are not stored
  assign irq_out = |(interrupt_flags_reg & interrupt_enables_reg & `MRSIRQ_FLAG_MASK);

  always @(posedge clk_in)
  begin
    if (srst_in)
    begin
      avs_readdata_out <= 32'h0000_0000;
      avs_response_out <= 2'b00;
    end
    else if (ans_load)
    begin
      avs_response_out <= mapped(avs_address_in) ? 2'b00 : 2'b11;
      if (avs_read_in)
      begin
        case (avs_address_in)
          `MRSIRQ_OFF_FLAGS:   avs_readdata_out <= {16'h0000, interrupt_flags_reg};
          `MRSIRQ_OFF_ENABLES: avs_readdata_out <= {16'h0000, interrupt_enables_reg};
          `MRSIRQ_OFF_STATUS:  avs_readdata_out <= {16'h0000, sensor_status_reg};
          default:             avs_readdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// ==== testbench/mrsirq_assertions.sv ====
// assertion checker for the sensor interrupt block
`timescale 1ns/10ps
module mrsirq_chk
(
  input wire        clk_in,
  input wire        srst_in,
  input wire [3:0]  avs_address_in,
  input wire        avs_read_in,
  input wire        avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [31:0] avs_readdata_out,
  input wire        avs_waitrequest_out,
  input wire [1:0]  avs_response_out,
  input wire        measuring_active_in,
  input wire [2:0]  phase_number_in,
  input wire        irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  wire       rd = avs_read_in && !avs_waitrequest_out;
  wire       wt = avs_write_in && !avs_waitrequest_out;
  wire [3:0] a  = avs_address_in;
  // status is a delayed copy loaded in the wait cycle, so the read shows inputs from two cycles back
  property p_act; rd && a == 4'h8 |-> avs_readdata_out[4] == $past(measuring_active_in, 2); endproperty
  a_act: assert property (p_act) else $error("bad active bit");
  property p_ph; rd && a == 4'h8 |-> avs_readdata_out[3:0] == {1'b0, $past(phase_number_in, 2)}; endproperty
  a_ph: assert property (p_ph) else $error("bad phase");
  property p_flg; rd && a == 4'h0 |-> (avs_readdata_out & 32'hffffe850) == 0; endproperty
  a_flg: assert property (p_flg) else $error("reserved flag set");
  property p_en; rd && a == 4'h4 |-> avs_readdata_out[31:13] == 0; endproperty
  a_en: assert property (p_en) else $error("enable top bits set");
  property p_unm; rd && a[3:2] == 2'b11 |-> avs_response_out == 2'b11 && avs_readdata_out == 0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_off; wt && a == 4'h4 && avs_writedata_in[12:0] == 0 |=> !irq_out; endproperty
  a_off: assert property (p_off) else $error("irq without enable");
  property p_fall; $fell(irq_out) |-> $past(wt); endproperty
  a_fall: assert property (p_fall) else $error("irq dropped alone");
  property p_wait; (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out; endproperty
  a_wait: assert property (p_wait) else $error("no answer");
  c_irq: cover property ($rose(irq_out));
  c_unm: cover property (rd && a == 4'hc);
  c_two: cover property (rd && a == 4'h8 ##[1:8] rd && a == 4'h8);
endmodule
bind mrsirq_top mrsirq_chk u_chk (.*);

// ==== testbench/tb_mr_sensor_irq_status.sv ====
// self-checking bench for the sensor interrupt block
`timescale 1ns/10ps
module tb_mr_sensor_irq_status;
  logic        clk_in = 0, srst_in = 1, rd = 0, wr = 0, meas = 0;
  logic [3:0]  adr = 0;
  logic [31:0] wd = 0, q, s = 89;
  logic [9:0]  ev = 0;
  logic [11:0] cmpv = 0;
  logic [2:0]  ph = 0;
  logic [1:0]  rp;
  wire  [1:0]  resp;
  wire  [31:0] rdat;
  wire         wq, irq;
  int          n_errors = 0, checks_done = 0, cyc = 0;
  int          pos[10] = '{12, 10, 9, 8, 7, 5, 3, 2, 1, 0};
  mrsirq_top u_mrsirq_top (.clk_in(clk_in), .srst_in(srst_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hf), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wq), .avs_response_out(resp), .unit_count_in(ev[0] ? cmpv : cmpv + 12'h1),
    .unit_compare_in(cmpv), .evt2_underflow_in(ev[1]), .evt1_underflow_in(ev[2]), .evt0_underflow_in(ev[3]),
    .cmp1_change_in(ev[4]), .cmp0_change_in(ev[5]), .phase_drop_in(ev[6]), .stop_detect_in(ev[7]),
    .reverse_detect_in(ev[8]), .forward_detect_in(ev[9]), .measuring_active_in(meas),
    .phase_number_in(ph), .irq_out(irq));
  initial forever #4 clk_in = ~clk_in;
  function logic [31:0] rnd(); s ^= s << 13; s ^= s >> 17; s ^= s << 5; return s; endfunction
  task end_sim();
    if (n_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is seen low; answer taken at that same edge
  task bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= {16'h0, d};
    do @(posedge clk_in); while (wq !== 1'b0);
    q = rdat;
    rp = resp;
    rd <= 0;
    wr <= 0;
    @(posedge clk_in);
  endtask
  task rc(input logic [3:0] a, input logic [31:0] e);
    bus(0, a, 0);
    chk(q, e);
  endtask
  task pulse(input int i);
    ev[i] <= 1;
    @(posedge clk_in);
    ev <= 0;
    @(posedge clk_in);
  endtask
  // the whole run needs well under a thousand cycles
  always @(posedge clk_in) if (++cyc == 5000)
  begin
    n_errors++;
    end_sim();
  end
  initial
  begin
    repeat (3) @(posedge clk_in);
    srst_in <= 0;
    cmpv <= rnd();
    @(posedge clk_in);
    rc(0, 0);
    chk({30'h0, rp}, 32'h0);
    rc(4, 0);
    repeat (4)
    begin
      bus(1, 4, rnd() & 16'h17af);
      rc(4, s & 32'h17af);
    end
    bus(1, 4, 0);
    foreach (pos[i])
    begin
      pulse(i);
      rc(0, 32'h1 << pos[i]);
      chk(irq, 0);
      bus(1, 4, 16'h1 << pos[i]);
      chk(irq, 1);
      bus(1, 0, ~(16'h1 << pos[i]));
      rc(0, 32'h1 << pos[i]);
      bus(1, 0, 16'hffff);
      chk(irq, 0);
      rc(0, 0);
      bus(1, 4, 0);
    end
    repeat (6)
    begin
      meas <= rnd() >> 3;
      ph <= s;
      repeat (2) @(posedge clk_in);
      repeat (2) rc(8, {27'h0, s[3], 1'b0, s[2:0]});
    end
    rc(4'hc, 0);
    chk({30'h0, rp}, 32'h3);
    end_sim();
  end
endmodule
